// ==== tb_top.sv ====
// Self-checking bench for the endpoint control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ued_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [1:0] bresp, rresp, hc;
  logic hv, pv, dp, dm, busr, pull, run, irq, htg, fsm, frz;
  logic [1:0] pt;
  logic [2:0] pe, fep, h;
  logic [6:0] pa;
  logic [33:0] r;
  int fails, checked, cyc;
  ued_ctrl #(.IDLE_CYCLES(20)) i_ued_ctrl (.aclk(aclk), .aresetn(aresetn), .s_awvalid(awv),
    .s_awready(awr), .s_awaddr(awa), .s_awprot(3'h0), .s_wvalid(wv), .s_wready(wr_r),
    .s_wdata(wd), .s_wstrb(4'hf), .s_bvalid(bv), .s_bready(br), .s_bresp(bresp),
    .s_arvalid(arv), .s_arready(arr), .s_araddr(ara), .s_arprot(3'h0), .s_rvalid(rv),
    .s_rready(rr), .s_rdata(rd_d), .s_rresp(rresp), .line_dp(dp), .line_dm(dm),
    .bus_reset(busr), .pkt_valid(pv), .pkt_type(pt), .pkt_ep(pe), .pkt_addr(pa),
    .hs_valid(hv), .hs_code(hc), .hs_toggle(htg), .pullup_en(pull), .fs_mode(fsm),
    .clk_frozen(frz), .flow_ep(fep), .flow_run(run), .irq(irq));
  ued_host_model i_ued_host_model (.aclk(aclk), .hs_valid(hv), .hs_code(hc), .pkt_valid(pv),
    .pkt_type(pt), .pkt_ep(pe), .pkt_addr(pa), .line_dp(dp), .line_dm(dm), .bus_reset(busr));
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {awv, wv, br} <= 3'h7;
    awa <= a;
    wd <= d;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    chk({32'h0, bresp}, {32'h0, RESP_OKAY});
    // Let an edge pass so the next call does not raise bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    {arv, rr} <= 2'h3;
    ara <= a;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    r = {rresp, rd_d};
    rr <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(r, {RESP_OKAY, e});
  endtask
  task automatic tk(input logic [1:0] t, input logic [6:0] a, input logic [2:0] e);
    i_ued_host_model.send(t, a, h);
    chk({31'h0, h}, {31'h0, e});
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_reset;
    rc(REG_CTRL, 32'h2);
    chk({33'h0, pull}, 34'h0);
    rc(REG_ADDR, 32'h0);
    $display("reset done");
  endtask
  task automatic t_setup;
    wr(REG_CTRL, 32'h1);
    chk({33'h0, pull}, 34'h1);
    tk(PKT_SETUP, 7'h0, 3'h0);
    wr(REG_EPCFG, 32'ha1);
    rc(REG_EPCFG, 32'h1a1);
    tk(PKT_SETUP, 7'h0, {1'b1, HS_ACK});
    rc(REG_EPSTA, 32'h5);
    $display("setup done");
  endtask
  // Value first, valid in a later access
  task automatic t_addr;
    wr(REG_ADDR, 32'h05);
    tk(PKT_SETUP, 7'h5, 3'h0);
    wr(REG_ADDR, 32'h85);
    tk(PKT_SETUP, 7'h0, 3'h0);
    tk(PKT_SETUP, 7'h5, {1'b1, HS_ACK});
    i_ued_host_model.pulse_reset();
    rc(REG_ADDR, 32'h0);
    $display("address done");
  endtask
  task automatic t_stall;
    wr(REG_EPCFG, 32'he1);
    tk(PKT_IN, 7'h0, {1'b1, HS_NAK});
    tk(PKT_OUT, 7'h0, {1'b1, HS_STALL});
    tk(PKT_OUT, 7'h0, {1'b1, HS_STALL});
    tk(PKT_SETUP, 7'h0, {1'b1, HS_ACK});
    rc(REG_EPCFG, 32'h1a1);
    tk(PKT_OUT, 7'h0, {1'b1, HS_ACK});
    rc(REG_EPSTA, 32'h7);
    wr(REG_EPSTA, 32'h4);
    rc(REG_EPSTA, 32'h4);
    // A second OUT leaves the toggle set, so its reset below is visible
    tk(PKT_OUT, 7'h0, {1'b1, HS_ACK});
    wr(REG_EPCFG, 32'ha0);
    rc(REG_EPCFG, 32'ha0);
    tk(PKT_SETUP, 7'h0, 3'h0);
    wr(REG_EPCFG, 32'h3f);
    rc(REG_EPCFG, 32'h3f);
    wr(REG_EPCFG, 32'h21);
    tk(PKT_OUT, 7'h0, {1'b1, HS_ACK});
    chk({33'h0, htg}, 34'h0);
    rc(REG_EPSTA, 32'h1e);
    wr(REG_EPCFG, 32'ha1);
    rc(REG_EPSTA, 32'h6);
    $display("stall done");
  endtask
  task automatic t_flow;
    wr(REG_CTRL, 32'h09);
    wr(REG_EP_NUMBER_SEL, 32'h3);
    wr(REG_CTRL, 32'h19);
    chk({30'h0, run, fep}, 34'hb);
    wr(REG_CTRL, 32'h09);
    chk({30'h0, run, fep}, 34'h3);
    wr(REG_CTRL, 32'h01);
    rc(REG_EP_NUMBER_SEL, 32'h0);
    rd(8'h40);
    chk(r, {RESP_SLVERR, 32'h0});
    $display("flow done");
  endtask
  // Idle lines give suspend; a K state gives wake
  task automatic t_susp;
    wr(REG_INT, 32'h0);
    // Suspend fires once per idle stretch, so line activity re-arms it first
    i_ued_host_model.set_line(2'h1);
    i_ued_host_model.set_line(LINE_J);
    repeat (40) @(posedge aclk);
    rc(REG_INT, 32'h101);
    chk({33'h0, fsm}, 34'h1);
    chk({33'h0, irq}, 34'h0);
    wr(REG_CTRL, 32'h05);
    chk({33'h0, frz}, 34'h1);
    wr(REG_INTEN, 32'h2);
    i_ued_host_model.set_line(2'h1);
    repeat (5) @(posedge aclk);
    i_ued_host_model.set_line(LINE_J);
    repeat (5) @(posedge aclk);
    rc(REG_INT, 32'h102);
    chk({33'h0, irq}, 34'h1);
    wr(REG_CTRL, 32'h01);
    chk({33'h0, frz}, 34'h0);
    $display("suspend done");
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    {aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    {fails, checked, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_setup();
    t_addr();
    t_stall();
    t_flow();
    t_susp();
    results();
  end
endmodule
`default_nettype wire

// ==== ued_ctrl.sv ====
// USB device endpoint control: register slave, endpoint state and handshakes
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ued_ctrl #(
  parameter int NEP         = 7,
  parameter int RAM_BYTES   = 1024,
  parameter int IDLE_CYCLES = ued_pkg::SUSPEND_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      s_awvalid,
  output logic                           s_awready,
  input  wire logic [7:0]                s_awaddr,
  input  wire logic [2:0]                s_awprot,
  input  wire logic                      s_wvalid,
  output logic                           s_wready,
  input  wire logic [31:0]               s_wdata,
  input  wire logic [3:0]                s_wstrb,
  output logic                           s_bvalid,
  input  wire logic                      s_bready,
  output logic [1:0]                     s_bresp,
  input  wire logic                      s_arvalid,
  output logic                           s_arready,
  input  wire logic [7:0]                s_araddr,
  input  wire logic [2:0]                s_arprot,
  output logic                           s_rvalid,
  input  wire logic                      s_rready,
  output logic [31:0]                    s_rdata,
  output logic [1:0]                     s_rresp,
  input  wire logic                      line_dp,
  input  wire logic                      line_dm,
  input  wire logic                      bus_reset,
  input  wire logic                      pkt_valid,
  input  wire logic [1:0]                pkt_type,
  input  wire logic [ued_pkg::EPW-1:0]   pkt_ep,
  input  wire logic [ued_pkg::ADDR_W-1:0] pkt_addr,
  output logic                           hs_valid,
  output logic [1:0]                     hs_code,
  output logic                           hs_toggle,
  output logic                           pullup_en,
  output logic                           fs_mode,
  output logic                           clk_frozen,
  output logic [ued_pkg::EPW-1:0]        flow_ep,
  output logic                           flow_run,
  output logic                           irq
);
  import ued_pkg::*;

  typedef struct packed {
    logic                       aw_have;
    logic [7:0]                 aw_a;
    logic                       w_have;
    logic [31:0]                w_d;
    logic [3:0]                 w_s;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       macro_on;
    logic                       detach;
    logic                       freeze;
    logic                       side;
    logic                       go;
    logic                       run;
    logic [EPW-1:0]             cpu_ep;
    logic [EPW-1:0]             flow_ep;
    logic [ADDR_W-1:0]          addr;
    logic                       addr_valid;
    logic                       susp;
    logic                       wake;
    logic                       fs;
    logic                       en_susp;
    logic                       en_wake;
    logic [NEP-1:0]             act;
    logic [NEP-1:0]             bank;
    logic [NEP-1:0]             res;
    logic [NEP-1:0]             stall;
    logic [NEP-1:0]             ctl;
    logic [NEP-1:0]             setup;
    logic [NEP-1:0]             outrx;
    logic [NEP-1:0]             inrdy;
    logic [NEP-1:0]             fifo;
    logic [NEP-1:0]             tog;
    logic [NEP-1:0][SIZE_W-1:0] size;
    logic                       hs_valid;
    logic [1:0]                 hs_code;
    logic                       hs_toggle;
    logic                       irq;
  } ued_st_t;

  // Detached at reset, so the host sees nothing until firmware is ready
  localparam ued_st_t ST_RST = '{detach: 1'b1, inrdy: '1, default: '0};

  ued_st_t        st;
  ued_st_t        nx;
  logic [NEP-1:0] cfg_ok;
  logic           pkt_ok;
  logic           susp_evt;
  logic           wake_evt;

  ued_line_mon #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_mon (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .line_dp  (line_dp),
    .line_dm  (line_dm),
    .susp_evt (susp_evt),
    .wake_evt (wake_evt)
  );

  // Valid only if active, reserved and the banks fit the shared buffer ram
  for (genvar i = 0; i < NEP; i++) begin : g_ep
    assign cfg_ok[i] = st.act[i] && st.res[i] &&
      ((32'(EP_MIN_BYTES) << ({1'b0, st.size[i]} + 4'(st.bank[i])))
        <= 32'(RAM_BYTES));
  end

  // Address filter uses the default address until the valid bit is set
  assign pkt_ok = pkt_valid && st.macro_on && ({1'b0, pkt_ep} < 4'(NEP)) &&
                  cfg_ok[pkt_ep] &&
                  (pkt_addr == (st.addr_valid ? st.addr : DEF_ADDR));

  always_comb begin
    logic [EPW-1:0] c;
    logic [EPW-1:0] e;
    logic [31:0]    rd;
    logic [31:0]    wd;
    logic [1:0]     rr;
    c           = st.cpu_ep;
    e           = pkt_ep;
    rd          = '0;
    wd          = st.w_d;
    rr          = RESP_OKAY;
    nx          = st;
    nx.hs_valid = 1'b0;

    // Read channel: answer registered on the same edge that takes the address
    if (st.rvalid && s_rready) begin
      nx.rvalid = 1'b0;
    end
    if (s_arvalid && st.arready) begin
      if (s_araddr == REG_CTRL) begin
        rd[CTRL_MACRO]  = st.macro_on;
        rd[CTRL_DETACH] = st.detach;
        rd[CTRL_FREEZE] = st.freeze;
        rd[CTRL_SIDE]   = st.side;
        rd[CTRL_GO]     = st.go;
      end else if (s_araddr == REG_ADDR) begin
        rd[ADDR_W-1:0]  = st.addr;
        rd[ADDR_VALID]  = st.addr_valid;
      end else if (s_araddr == REG_INT) begin
        rd[INT_SUSP] = st.susp;
        rd[INT_WAKE] = st.wake;
        rd[INT_FS]   = st.fs;
      end else if (s_araddr == REG_INTEN) begin
        rd[INT_SUSP] = st.en_susp;
        rd[INT_WAKE] = st.en_wake;
      end else if (s_araddr == REG_EP_NUMBER_SEL) begin
        rd[EPW-1:0] = st.side ? st.flow_ep : st.cpu_ep;
      end else if (s_araddr == REG_EPCFG) begin
        if ({1'b0, c} < 4'(NEP)) begin
          rd[CFG_ACT]                 = st.act[c];
          rd[CFG_SIZE +: SIZE_W]      = st.size[c];
          rd[CFG_BANK]                = st.bank[c];
          rd[CFG_RES]                 = st.res[c];
          rd[CFG_STALL]               = st.stall[c];
          rd[CFG_CTL]                 = st.ctl[c];
          rd[CFG_OK]                  = cfg_ok[c];
        end
      end else if (s_araddr == REG_EPSTA) begin
        if ({1'b0, c} < 4'(NEP)) begin
          rd[STA_SETUP] = st.setup[c];
          rd[STA_OUT]   = st.outrx[c];
          rd[STA_IN]    = st.inrdy[c];
          // Bank bits mean nothing on a control endpoint
          rd[STA_BANK]  = st.fifo[c] && !st.ctl[c];
          rd[STA_RW]    = st.fifo[c] && !st.ctl[c];
        end
      end else begin
        rr = RESP_SLVERR;
      end
      nx.rvalid = 1'b1;
      nx.rdata  = rd;
      nx.rresp  = rr;
    end
    nx.arready = !nx.rvalid;

    // Write channel: address and data taken in either order
    if (st.bvalid && s_bready) begin
      nx.bvalid = 1'b0;
    end
    if (s_awvalid && st.awready) begin
      nx.aw_have = 1'b1;
      nx.aw_a    = s_awaddr;
    end
    if (s_wvalid && st.wready) begin
      nx.w_have = 1'b1;
      nx.w_d    = s_wdata;
      nx.w_s    = s_wstrb;
    end
    if (st.aw_have && st.w_have && !st.bvalid) begin
      nx.aw_have = 1'b0;
      nx.w_have  = 1'b0;
      nx.bvalid  = 1'b1;
      nx.bresp   = RESP_OKAY;
      // All fields sit in the low byte; other lanes are ignored
      if (st.aw_a == REG_CTRL) begin
        if (st.w_s[0]) begin
          nx.macro_on = wd[CTRL_MACRO];
          nx.detach   = wd[CTRL_DETACH];
          nx.freeze   = wd[CTRL_FREEZE];
          nx.side     = wd[CTRL_SIDE];
          nx.go       = wd[CTRL_GO];
        end
      end else if (st.aw_a == REG_ADDR) begin
        if (st.w_s[0]) begin
          nx.addr       = wd[ADDR_W-1:0];
          nx.addr_valid = wd[ADDR_VALID];
        end
      end else if (st.aw_a == REG_INT) begin
        // Writing zero clears a flag, writing one leaves it alone
        if (st.w_s[0]) begin
          nx.susp = st.susp && wd[INT_SUSP];
          nx.wake = st.wake && wd[INT_WAKE];
        end
      end else if (st.aw_a == REG_INTEN) begin
        if (st.w_s[0]) begin
          nx.en_susp = wd[INT_SUSP];
          nx.en_wake = wd[INT_WAKE];
        end
      end else if (st.aw_a == REG_EP_NUMBER_SEL) begin
        if (st.w_s[0]) begin
          if (st.side) begin
            nx.flow_ep = wd[EPW-1:0];
          end else begin
            nx.cpu_ep = wd[EPW-1:0];
          end
        end
      end else if (st.aw_a == REG_EPCFG) begin
        if (st.w_s[0] && ({1'b0, c} < 4'(NEP))) begin
          nx.act[c]   = wd[CFG_ACT];
          nx.size[c]  = wd[CFG_SIZE +: SIZE_W];
          nx.bank[c]  = wd[CFG_BANK];
          nx.res[c]   = wd[CFG_RES];
          nx.stall[c] = wd[CFG_STALL];
          nx.ctl[c]   = wd[CFG_CTL];
        end
      end else if (st.aw_a == REG_EPSTA) begin
        // Clearing a flag hands the bank back to the hardware
        if (st.w_s[0] && ({1'b0, c} < 4'(NEP))) begin
          nx.setup[c] = st.setup[c] && wd[STA_SETUP];
          nx.outrx[c] = st.outrx[c] && wd[STA_OUT];
          nx.inrdy[c] = st.inrdy[c] && wd[STA_IN];
          nx.fifo[c]  = st.fifo[c] && wd[STA_BANK];
        end
      end else begin
        nx.bresp = RESP_SLVERR;
      end
    end
    nx.awready = !nx.aw_have && !nx.bvalid;
    nx.wready  = !nx.w_have && !nx.bvalid;

    // Address invalidated by macro off or bus reset
    if (!nx.macro_on) begin
      nx.addr_valid = 1'b0;
    end
    if (bus_reset) begin
      nx.addr       = DEF_ADDR;
      nx.addr_valid = 1'b0;
    end

    // Line events come after firmware clears, so a set always wins
    if (susp_evt) begin
      nx.susp = 1'b1;
      nx.fs   = 1'b1;
      nx.wake = 1'b0;
    end
    if (wake_evt) begin
      nx.wake = 1'b1;
      nx.susp = 1'b0;
    end

    // Handshake choice; retry (bank not ready) is checked before stall
    if (pkt_ok) begin
      nx.hs_valid  = 1'b1;
      nx.hs_toggle = st.tog[e];
      if (pkt_type == PKT_SETUP) begin
        nx.hs_code  = HS_ACK;
        nx.setup[e] = 1'b1;
        nx.outrx[e] = 1'b0;
        nx.stall[e] = 1'b0;
        nx.tog[e]   = 1'b1;
      end else if (pkt_type == PKT_OUT) begin
        if (st.outrx[e] || st.fifo[e]) begin
          nx.hs_code = HS_NAK;
        end else if (st.stall[e]) begin
          nx.hs_code = HS_STALL;
        end else begin
          nx.hs_code  = HS_ACK;
          nx.outrx[e] = 1'b1;
          nx.fifo[e]  = !st.ctl[e];
          nx.tog[e]   = !st.tog[e];
        end
      end else begin
        if (st.inrdy[e]) begin
          nx.hs_code = HS_NAK;
        end else if (st.stall[e]) begin
          nx.hs_code = HS_STALL;
        end else begin
          nx.hs_code  = HS_DATA;
          nx.inrdy[e] = 1'b1;
          nx.tog[e]   = !st.tog[e];
        end
      end
    end

    // Inactive endpoints sit in reset; configuration fields are kept
    // Applied last, so a packet in the deactivating cycle leaves no flag behind
    for (int i = 0; i < NEP; i++) begin
      if (!nx.act[i]) begin
        nx.setup[i] = 1'b0;
        nx.outrx[i] = 1'b0;
        nx.fifo[i]  = 1'b0;
        nx.inrdy[i] = 1'b1;
        nx.tog[i]   = 1'b0;
      end
    end

    nx.run = nx.go && nx.macro_on;
    nx.irq = (nx.susp && nx.en_susp) || (nx.wake && nx.en_wake);
  end

  // Single synchronous register for the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign s_awready  = st.awready;
  assign s_wready   = st.wready;
  assign s_bvalid   = st.bvalid;
  assign s_bresp    = st.bresp;
  assign s_arready  = st.arready;
  assign s_rvalid   = st.rvalid;
  assign s_rdata    = st.rdata;
  assign s_rresp    = st.rresp;
  assign hs_valid   = st.hs_valid;
  assign hs_code    = st.hs_code;
  assign hs_toggle  = st.hs_toggle;
  assign pullup_en  = !st.detach;
  assign fs_mode    = st.fs;
  assign clk_frozen = st.freeze;
  assign flow_ep    = st.flow_ep;
  assign flow_run   = st.run;
  assign irq        = st.irq;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_addr_default;
    pkt_valid && !st.addr_valid && (pkt_addr != DEF_ADDR) |=> !hs_valid;
  endproperty
  a_addr_default: assert property (p_addr_default)
    else $error("Nonzero address answered while address invalid");

  property p_detach_reset;
    $rose(aresetn) |-> !pullup_en ##1 !pullup_en;
  endproperty
  a_detach_reset: assert property (p_detach_reset)
    else $error("Pull-up on right after reset");

  property p_wake_clears_susp;
    wake_evt |=> st.wake && !st.susp;
  endproperty
  a_wake_clears_susp: assert property (p_wake_clears_susp)
    else $error("Wake did not clear suspend");

  property p_suspend_entry;
    susp_evt && !wake_evt |=> st.susp && fs_mode && !st.wake;
  endproperty
  a_suspend_entry: assert property (p_suspend_entry)
    else $error("Suspend entry incomplete");

  property p_unconfigured_silent;
    pkt_valid && !cfg_ok[pkt_ep] |=> !hs_valid;
  endproperty
  a_unconfigured_silent: assert property (p_unconfigured_silent)
    else $error("Handshake on unconfigured endpoint");

  property p_retry_first;
    pkt_ok && (pkt_type == PKT_IN) && st.inrdy[pkt_ep] |=> hs_valid && hs_code == HS_NAK;
  endproperty
  a_retry_first: assert property (p_retry_first)
    else $error("Retry did not take precedence");

  property p_stall_status;
    pkt_ok && (pkt_type == PKT_IN) && !st.inrdy[pkt_ep] && st.stall[pkt_ep]
      |=> hs_code == HS_STALL;
  endproperty
  a_stall_status: assert property (p_stall_status)
    else $error("Stall request not answered with STALL");

  property p_setup_ack;
    pkt_ok && (pkt_type == PKT_SETUP)
      |=> hs_code == HS_ACK && st.setup[$past(pkt_ep)] && !st.outrx[$past(pkt_ep)];
  endproperty
  a_setup_ack: assert property (p_setup_ack)
    else $error("SETUP not acked or OUT flag set");

  property p_ep_held;
    !st.act[0] |-> !st.setup[0] && !st.outrx[0] && st.inrdy[0] && !st.tog[0];
  endproperty
  a_ep_held: assert property (p_ep_held)
    else $error("Inactive endpoint not held in reset");

  property p_flow_pause;
    !st.go |-> !flow_run;
  endproperty
  a_flow_pause: assert property (p_flow_pause)
    else $error("Flow channel runs with go cleared");
endmodule
`default_nettype wire

// ==== ued_host_model.sv ====
// Host-side model: sends tokens, drives the data lines and bus reset
`timescale 1ns/1ps
`default_nettype none
module ued_host_model (
  input  wire logic       aclk,
  input  wire logic       hs_valid,
  input  wire logic [1:0] hs_code,
  output logic            pkt_valid,
  output logic [1:0]      pkt_type,
  output logic [2:0]      pkt_ep,
  output logic [6:0]      pkt_addr,
  output logic            line_dp,
  output logic            line_dm,
  output logic            bus_reset
);
  // Lines idle at J
  initial begin
    {pkt_valid, pkt_type, pkt_ep, pkt_addr, bus_reset} = '0;
    {line_dp, line_dm} = 2'h2;
  end
  // One token; the answer is sampled one edge after it is taken
  task automatic send(input logic [1:0] t, input logic [6:0] a, output logic [2:0] r);
    pkt_valid <= 1'b1;
    pkt_type  <= t;
    pkt_addr  <= a;
    @(posedge aclk);
    pkt_valid <= 1'b0;
    pkt_addr  <= ~a; // Released address scrambled, never left stale; type keeps its value
    @(posedge aclk);
    r = {hs_valid, hs_code};
  endtask
  task automatic set_line(input logic [1:0] v);
    {line_dp, line_dm} <= v;
    @(posedge aclk);
  endtask
  task automatic pulse_reset;
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ==== ued_line_mon.sv ====
// Line monitor: synchronises data lines, detects suspend idle and wake
`timescale 1ns/1ps
`default_nettype none
module ued_line_mon #(
  parameter int IDLE_CYCLES = ued_pkg::SUSPEND_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_dp,
  input  wire logic line_dm,
  output logic      susp_evt,
  output logic      wake_evt
);
  import ued_pkg::*;

  typedef struct packed {
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [1:0]  prev;
    logic [31:0] cnt;
    logic        fired;
    logic        susp;
    logic        wake;
  } ued_mon_t;

  localparam ued_mon_t MON_RST = '{s1: LINE_J, s2: LINE_J, prev: LINE_J, default: '0};

  ued_mon_t st;
  ued_mon_t nx;

  // Stage one feeds stage two only; all decisions look at stage two
  always_comb begin
    nx      = st;
    nx.s1   = {line_dp, line_dm};
    nx.s2   = st.s1;
    nx.prev = st.s2;
    nx.susp = 1'b0;
    nx.wake = (st.s2 != LINE_J) && (st.prev == LINE_J);
    if (st.s2 != st.prev) begin
      nx.cnt   = '0;
      nx.fired = 1'b0;
    end else if (!st.fired) begin
      nx.cnt = st.cnt + 32'h1;
      // One pulse per idle stretch, so firmware is not flooded
      if (st.cnt + 32'h1 >= 32'(IDLE_CYCLES)) begin
        nx.susp  = 1'b1;
        nx.fired = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= MON_RST;
    end else begin
      st <= nx;
    end
  end

  assign susp_evt = st.susp;
  assign wake_evt = st.wake;

  property p_wake_on_activity;
    @(posedge aclk) disable iff (!aresetn)
    (st.s2 != LINE_J) && (st.prev == LINE_J) |=> wake_evt;
  endproperty
  a_wake_on_activity: assert property (p_wake_on_activity)
    else $error("Wake not flagged on non-idle line");
endmodule
`default_nettype wire

// ==== ued_pkg.sv ====
// Shared constants for the USB device endpoint control block
package ued_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_INT   = 8'h08;
  localparam logic [7:0] REG_INTEN = 8'h0c;
  localparam logic [7:0] REG_EP_NUMBER_SEL = 8'h10;
  localparam logic [7:0] REG_EPCFG = 8'h14;
  localparam logic [7:0] REG_EPSTA = 8'h18;

  // Control register fields
  localparam int CTRL_MACRO  = 0;
  localparam int CTRL_DETACH = 1;
  localparam int CTRL_FREEZE = 2;
  localparam int CTRL_SIDE   = 3;
  localparam int CTRL_GO     = 4;

  // Address register fields
  localparam int ADDR_W     = 7;
  localparam int ADDR_VALID = 7;
  localparam logic [ADDR_W-1:0] DEF_ADDR = 7'h00;

  // Event flag and enable fields
  localparam int INT_SUSP = 0;
  localparam int INT_WAKE = 1;
  localparam int INT_FS   = 8;

  // Endpoint configuration fields
  localparam int EPW      = 3;
  localparam int CFG_ACT  = 0;
  localparam int CFG_SIZE = 1;
  localparam int SIZE_W   = 3;
  localparam int CFG_BANK = 4;
  localparam int CFG_RES  = 5;
  localparam int CFG_STALL = 6;
  localparam int CFG_CTL  = 7;
  localparam int CFG_OK   = 8;
  localparam int EP_MIN_BYTES = 8;

  // Endpoint status fields
  localparam int STA_SETUP = 0;
  localparam int STA_OUT   = 1;
  localparam int STA_IN    = 2;
  localparam int STA_BANK  = 3;
  localparam int STA_RW    = 4;

  // Packet kinds from the protocol engine
  localparam logic [1:0] PKT_SETUP = 2'h0;
  localparam logic [1:0] PKT_OUT   = 2'h1;
  localparam logic [1:0] PKT_IN    = 2'h2;

  // Handshake answers
  localparam logic [1:0] HS_ACK   = 2'h0;
  localparam logic [1:0] HS_NAK   = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_DATA  = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Idle line state {dp, dm} in full speed
  localparam logic [1:0] LINE_J = 2'h2;

  // Suspend timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUSPEND_US    = 3000;
  localparam int SUSPEND_CYC   = SUSPEND_US * 1000 / CLK_PERIOD_NS;
endpackage
